// ### hw/mtxu_defs.vh
`ifndef MTXU_DEFS_VH
`define MTXU_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MTXU_AW             8
`define MTXU_OFF_PAGE_TABLE_ENTRY_HIGH       8'h00
`define MTXU_OFF_PAGE_TABLE_ENTRY_LOW       8'h04
`define MTXU_OFF_TEA        8'h08
`define MTXU_OFF_TRANSLATION_CONTROL_REG      8'h0c
`define MTXU_OFF_EXCEPTION_EVENT_CODE     8'h10
`define MTXU_OFF_SPC        8'h14
`define MTXU_OFF_SSR        8'h18
`define MTXU_OFF_SR         8'h1c
`define MTXU_OFF_VBR        8'h20

// ----------------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------------
`define MTXU_SEL_PAGE_TABLE_ENTRY_HIGH       4'h0
`define MTXU_SEL_PAGE_TABLE_ENTRY_LOW       4'h1
`define MTXU_SEL_TEA        4'h2
`define MTXU_SEL_TRANSLATION_CONTROL_REG      4'h3
`define MTXU_SEL_EXCEPTION_EVENT_CODE     4'h4
`define MTXU_SEL_SPC        4'h5
`define MTXU_SEL_SSR        4'h6
`define MTXU_SEL_SR         4'h7
`define MTXU_SEL_VBR        4'h8
`define MTXU_SEL_NONE       4'hf

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MTXU_SR_MD          30
`define MTXU_SR_RB          29
`define MTXU_SR_BL          28
`define MTXU_TRANSLATION_CONTROL_REG_AT       0
`define MTXU_TRANSLATION_CONTROL_REG_TI       2
`define MTXU_TRANSLATION_CONTROL_REG_RC_LO    6
`define MTXU_TRANSLATION_CONTROL_REG_RC_HI    7
`define MTXU_TRANSLATION_CONTROL_REG_IX       9
`define MTXU_PAGE_TABLE_ENTRY_LOW_SH        1
`define MTXU_PAGE_TABLE_ENTRY_LOW_D         2
`define MTXU_PAGE_TABLE_ENTRY_LOW_C         3
`define MTXU_PAGE_TABLE_ENTRY_LOW_SZ        4
`define MTXU_PAGE_TABLE_ENTRY_LOW_PR_LO     5
`define MTXU_PAGE_TABLE_ENTRY_LOW_PR_HI     6
`define MTXU_PAGE_TABLE_ENTRY_LOW_V         8

// ----------------------------------------------------------------------
// Reset values, event codes and vector offsets
// ----------------------------------------------------------------------
`define MTXU_SR_RST         32'h70000000
`define MTXU_CODE_MISS_LD   12'h040
`define MTXU_CODE_MISS_ST   12'h060
`define MTXU_CODE_INITPW    12'h080
`define MTXU_CODE_PROT_LD   12'h0a0
`define MTXU_CODE_PROT_ST   12'h0c0
`define MTXU_CODE_RPT       12'h070
`define MTXU_CODE_RPT_PROT  12'h0d0
`define MTXU_VEC_MISS       32'h00000400
`define MTXU_VEC_FAULT      32'h00000100
`define MTXU_VEC_RPT_MISS   32'h00000100
`define MTXU_RESP_OKAY      2'b00
`define MTXU_RESP_SLVERR    2'b10

`endif

// ### hw/mtxu_top.v
`timescale 1ns/1ps
`default_nettype none
`include "mtxu_defs.vh"

// Operation
// - No tag match raises a miss fault
// - Forbidden access on valid match raises protection
// - Match with cleared valid raises invalid
// - Write to clean page raises initial-write fault
// - Check only when enabled, after address error
// - Fault loads page number into entry-high
// - Fault loads full address into fault register
// - Miss/invalid codes 040 load, 060 store
// - Protection codes 0A0 load, 0C0 store
// - Initial page write code is 080
// - Save faulting pc, or branch pc in slot
// - Copy status register into saved status
// - Set mode, block and bank bits
// - Miss: increment way counter or smallest free
// - Other faults load faulting way number
// - Miss branches to vector base plus 400
// - Other faults branch to base plus 100
// - Repeat loop codes 070 and 0D0
// - Repeat loop miss uses offset 100
// - Load entry copies high and low into TLB
// - Load entry uses way counter and index
module mtxu_top #(
  parameter WAY_W = 2,
  parameter IDX_W = 5
)(
  input  wire        I_MCLK,
  input  wire        I_RESET,
  input  wire [7:0]  I_AWADDR,
  input  wire        I_AWVALID,
  output wire        O_AWREADY,
  input  wire [31:0] I_WDATA,
  input  wire [3:0]  I_WSTRB,
  input  wire        I_WVALID,
  output wire        O_WREADY,
  output wire [1:0]  O_BRESP,
  output wire        O_BVALID,
  input  wire        I_BREADY,
  input  wire [7:0]  I_ARADDR,
  input  wire        I_ARVALID,
  output wire        O_ARREADY,
  output wire [31:0] O_RDATA,
  output wire [1:0]  O_RRESP,
  output wire        O_RVALID,
  input  wire        I_RREADY,
  input  wire        I_ACC_REQ,
  input  wire        I_ACC_WRITE,
  input  wire [31:0] I_ACC_VADDR,
  input  wire [31:0] I_ACC_PC,
  input  wire        I_ACC_IN_SLOT,
  input  wire [31:0] I_ACC_BRANCH_PC,
  input  wire        I_ACC_REPEAT,
  input  wire        I_ACC_ADDR_ERR,
  input  wire        I_LOAD_TRANSLATION_ENTRY_INSTRUCTION,
  input  wire        I_RTE,
  output wire        O_ACC_ACK,
  output wire        O_ACC_OK,
  output wire        O_ACC_FAULT,
  output wire [31:0] O_ACC_PADDR,
  output wire        O_EXC_TAKEN,
  output wire [31:0] O_EXC_TARGET,
  output wire [31:0] O_SR
);

  localparam NW   = 1 << WAY_W;
  localparam NENT = NW << IDX_W;
  localparam EW   = WAY_W + IDX_W;

  localparam FLT_NONE  = 3'd0;
  localparam FLT_MISS  = 3'd1;
  localparam FLT_PROT  = 3'd2;
  localparam FLT_INVAL = 3'd3;
  localparam FLT_INITW = 3'd4;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function [3:0] mtxu_dec;
    input [7:0] a;
    begin
      case ({a[7:2], 2'b00})
        `MTXU_OFF_PAGE_TABLE_ENTRY_HIGH:   mtxu_dec = `MTXU_SEL_PAGE_TABLE_ENTRY_HIGH;
        `MTXU_OFF_PAGE_TABLE_ENTRY_LOW:   mtxu_dec = `MTXU_SEL_PAGE_TABLE_ENTRY_LOW;
        `MTXU_OFF_TEA:    mtxu_dec = `MTXU_SEL_TEA;
        `MTXU_OFF_TRANSLATION_CONTROL_REG:  mtxu_dec = `MTXU_SEL_TRANSLATION_CONTROL_REG;
        `MTXU_OFF_EXCEPTION_EVENT_CODE: mtxu_dec = `MTXU_SEL_EXCEPTION_EVENT_CODE;
        `MTXU_OFF_SPC:    mtxu_dec = `MTXU_SEL_SPC;
        `MTXU_OFF_SSR:    mtxu_dec = `MTXU_SEL_SSR;
        `MTXU_OFF_SR:     mtxu_dec = `MTXU_SEL_SR;
        `MTXU_OFF_VBR:    mtxu_dec = `MTXU_SEL_VBR;
        default:          mtxu_dec = `MTXU_SEL_NONE;
      endcase
    end
  endfunction

  function [31:0] mtxu_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      b;
    begin
      mtxu_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          mtxu_merge[8*b +: 8] = nw[8*b +: 8];
        end
      end
    end
  endfunction

  function [IDX_W-1:0] mtxu_index;
    input [IDX_W-1:0] virtual_page_number;
    input [IDX_W-1:0] address_space_id;
    input             ix;
    begin
      mtxu_index = ix ? (virtual_page_number ^ address_space_id) : virtual_page_number;
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg  [31:0]      page_table_entry_high_r;
  reg  [31:0]      page_table_entry_low_r;
  reg  [31:0]      tea_r;
  reg  [11:0]      exception_event_code_r;
  reg  [31:0]      spc_r;
  reg  [31:0]      ssr_r;
  reg  [31:0]      sr_r;
  reg  [31:0]      vbr_r;
  reg              at_r;
  reg              ix_r;
  reg  [WAY_W-1:0] rc_r;
  reg              aw_hold_r;
  reg              w_hold_r;
  reg  [7:0]       aw_addr_r;
  reg  [31:0]      wdata_r;
  reg  [3:0]       wstrb_r;
  reg              bvalid_r;
  reg  [1:0]       bresp_r;
  reg              rvalid_r;
  reg  [1:0]       rresp_r;
  reg  [31:0]      rdata_r;
  reg              ack_r;
  reg              ok_r;
  reg              fault_r;
  reg  [31:0]      paddr_r;
  reg              exc_r;
  reg  [31:0]      target_r;
  reg  [NENT-1:0]  tlb_v_r;
  reg  [21:0]      tlb_vpn_r  [0:NENT-1];
  reg  [7:0]       tlb_address_space_id_r [0:NENT-1];
  reg  [18:0]      tlb_ppn_r  [0:NENT-1];
  reg  [1:0]       tlb_pr_r   [0:NENT-1];
  reg  [3:0]       tlb_flg_r  [0:NENT-1];

  // --------------------------------------------------------------------
  // Register bus handshakes
  // --------------------------------------------------------------------
  wire        sw_wr    = aw_hold_r && w_hold_r && !bvalid_r;
  wire [3:0]  sw_sel   = mtxu_dec(aw_addr_r);
  wire [3:0]  rd_sel   = mtxu_dec(I_ARADDR);
  wire [31:0] translation_control_reg_rd = {22'h000000, ix_r, 1'b0, rc_r, 5'h00, at_r};
  wire [31:0] translation_control_reg_wr = mtxu_merge(translation_control_reg_rd, wdata_r, wstrb_r);
  wire [31:0] evt_wr   = mtxu_merge({20'h00000, exception_event_code_r}, wdata_r,
                                    wstrb_r);

  assign O_AWREADY = !aw_hold_r && !bvalid_r;
  assign O_WREADY  = !w_hold_r && !bvalid_r;
  assign O_ARREADY = !rvalid_r;
  assign O_BVALID  = bvalid_r;
  assign O_BRESP   = bresp_r;
  assign O_RVALID  = rvalid_r;
  assign O_RRESP   = rresp_r;
  assign O_RDATA   = rdata_r;

  reg [31:0] rd_val;
  always @* begin
    case (rd_sel)
      `MTXU_SEL_PAGE_TABLE_ENTRY_HIGH:   rd_val = page_table_entry_high_r;
      `MTXU_SEL_PAGE_TABLE_ENTRY_LOW:   rd_val = page_table_entry_low_r;
      `MTXU_SEL_TEA:    rd_val = tea_r;
      `MTXU_SEL_TRANSLATION_CONTROL_REG:  rd_val = translation_control_reg_rd;
      `MTXU_SEL_EXCEPTION_EVENT_CODE: rd_val = {20'h00000, exception_event_code_r};
      `MTXU_SEL_SPC:    rd_val = spc_r;
      `MTXU_SEL_SSR:    rd_val = ssr_r;
      `MTXU_SEL_SR:     rd_val = sr_r;
      `MTXU_SEL_VBR:    rd_val = vbr_r;
      default:          rd_val = 32'h00000000;
    endcase
  end

  // --------------------------------------------------------------------
  // Lookup of the indexed set
  // --------------------------------------------------------------------
  reg  [IDX_W-1:0] lk_idx;
  reg  [EW-1:0]    lk_e;
  reg              lk_tag;
  reg              lk_hany;
  reg              lk_vany;
  reg              lk_free;
  reg  [WAY_W-1:0] lk_hway;
  reg  [WAY_W-1:0] lk_vway;
  reg  [WAY_W-1:0] lk_fway;
  reg  [WAY_W-1:0] lk_way;
  reg  [EW-1:0]    sel_e;
  reg              prot_bad;
  reg  [2:0]       flt;
  reg  [31:0]      pa;
  integer          w;

  always @* begin
    lk_idx  = mtxu_index(I_ACC_VADDR[16:12], page_table_entry_high_r[4:0], ix_r);
    lk_e    = {EW{1'b0}};
    lk_tag  = 1'b0;
    lk_hany = 1'b0;
    lk_vany = 1'b0;
    lk_free = 1'b0;
    lk_hway = {WAY_W{1'b0}};
    lk_vway = {WAY_W{1'b0}};
    lk_fway = {WAY_W{1'b0}};
    for (w = NW - 1; w >= 0; w = w - 1) begin
      lk_e   = {w[WAY_W-1:0], lk_idx};
      lk_tag = (tlb_flg_r[lk_e][`MTXU_PAGE_TABLE_ENTRY_LOW_SZ - 1] ?
                (tlb_vpn_r[lk_e][21:2] == I_ACC_VADDR[31:12]) :
                (tlb_vpn_r[lk_e] == I_ACC_VADDR[31:10])) &&
               (tlb_flg_r[lk_e][`MTXU_PAGE_TABLE_ENTRY_LOW_SH - 1] ||
                tlb_address_space_id_r[lk_e] == page_table_entry_high_r[7:0]);
      if (lk_tag) begin
        lk_hany = 1'b1;
        lk_hway = w[WAY_W-1:0];
        if (tlb_v_r[lk_e]) begin
          lk_vany = 1'b1;
          lk_vway = w[WAY_W-1:0];
        end
      end
      if (!tlb_v_r[lk_e]) begin
        lk_free = 1'b1;
        lk_fway = w[WAY_W-1:0];
      end
    end
    lk_way   = lk_vany ? lk_vway : lk_hway;
    sel_e    = {lk_way, lk_idx};
    prot_bad = (!sr_r[`MTXU_SR_MD] && !tlb_pr_r[sel_e][1]) ||
               (I_ACC_WRITE && !tlb_pr_r[sel_e][0]);
    if (!at_r || I_ACC_ADDR_ERR) begin
      flt = FLT_NONE;
    end else if (!lk_hany) begin
      flt = FLT_MISS;
    end else if (lk_vany && prot_bad) begin
      flt = FLT_PROT;
    end else if (!lk_vany) begin
      flt = FLT_INVAL;
    end else if (I_ACC_WRITE && !tlb_flg_r[sel_e][`MTXU_PAGE_TABLE_ENTRY_LOW_D - 1]) begin
      flt = FLT_INITW;
    end else begin
      flt = FLT_NONE;
    end
    if (!at_r) begin
      pa = I_ACC_VADDR;
    end else if (tlb_flg_r[sel_e][`MTXU_PAGE_TABLE_ENTRY_LOW_SZ - 1]) begin
      pa = {3'b000, tlb_ppn_r[sel_e][18:2], I_ACC_VADDR[11:0]};
    end else begin
      pa = {3'b000, tlb_ppn_r[sel_e], I_ACC_VADDR[9:0]};
    end
  end

  // --------------------------------------------------------------------
  // Exception code and vector
  // --------------------------------------------------------------------
  wire        rpt_err = I_ACC_ADDR_ERR && I_ACC_REPEAT;
  wire        take    = I_ACC_REQ && !sr_r[`MTXU_SR_BL] &&
                        (flt != FLT_NONE || rpt_err);
  reg  [11:0] code;
  reg  [31:0] vec;

  always @* begin
    case (flt)
      FLT_MISS, FLT_INVAL: begin
        code = I_ACC_REPEAT ? `MTXU_CODE_RPT :
               (I_ACC_WRITE ? `MTXU_CODE_MISS_ST : `MTXU_CODE_MISS_LD);
      end
      FLT_PROT: begin
        code = I_ACC_REPEAT ? `MTXU_CODE_RPT_PROT :
               (I_ACC_WRITE ? `MTXU_CODE_PROT_ST : `MTXU_CODE_PROT_LD);
      end
      FLT_INITW: begin
        code = I_ACC_REPEAT ? `MTXU_CODE_RPT : `MTXU_CODE_INITPW;
      end
      default: begin
        code = `MTXU_CODE_RPT;
      end
    endcase
    if (flt == FLT_MISS && !I_ACC_REPEAT) begin
      vec = `MTXU_VEC_MISS;
    end else if (flt == FLT_MISS) begin
      vec = `MTXU_VEC_RPT_MISS;
    end else begin
      vec = `MTXU_VEC_FAULT;
    end
  end

  // --------------------------------------------------------------------
  // Registers, bus slave and exception entry
  // --------------------------------------------------------------------
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      page_table_entry_high_r    <= 32'h00000000;
      page_table_entry_low_r    <= 32'h00000000;
      tea_r     <= 32'h00000000;
      exception_event_code_r  <= 12'h000;
      spc_r     <= 32'h00000000;
      ssr_r     <= 32'h00000000;
      sr_r      <= `MTXU_SR_RST;
      vbr_r     <= 32'h00000000;
      at_r      <= 1'b0;
      ix_r      <= 1'b0;
      rc_r      <= {WAY_W{1'b0}};
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `MTXU_RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= `MTXU_RESP_OKAY;
      rdata_r   <= 32'h00000000;
      ack_r     <= 1'b0;
      ok_r      <= 1'b0;
      fault_r   <= 1'b0;
      paddr_r   <= 32'h00000000;
      exc_r     <= 1'b0;
      target_r  <= 32'h00000000;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_hold_r <= 1'b1;
        wdata_r  <= I_WDATA;
        wstrb_r  <= I_WSTRB;
      end
      if (sw_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (sw_sel == `MTXU_SEL_NONE) ?
                     `MTXU_RESP_SLVERR : `MTXU_RESP_OKAY;
        case (sw_sel)
          `MTXU_SEL_PAGE_TABLE_ENTRY_HIGH:   page_table_entry_high_r <= mtxu_merge(page_table_entry_high_r, wdata_r, wstrb_r);
          `MTXU_SEL_PAGE_TABLE_ENTRY_LOW:   page_table_entry_low_r <= mtxu_merge(page_table_entry_low_r, wdata_r, wstrb_r);
          `MTXU_SEL_TEA:    tea_r  <= mtxu_merge(tea_r, wdata_r, wstrb_r);
          `MTXU_SEL_TRANSLATION_CONTROL_REG: begin
            at_r <= translation_control_reg_wr[`MTXU_TRANSLATION_CONTROL_REG_AT];
            ix_r <= translation_control_reg_wr[`MTXU_TRANSLATION_CONTROL_REG_IX];
            rc_r <= translation_control_reg_wr[`MTXU_TRANSLATION_CONTROL_REG_RC_HI:`MTXU_TRANSLATION_CONTROL_REG_RC_LO];
          end
          `MTXU_SEL_EXCEPTION_EVENT_CODE: exception_event_code_r <= evt_wr[11:0];
          `MTXU_SEL_SPC:    spc_r  <= mtxu_merge(spc_r, wdata_r, wstrb_r);
          `MTXU_SEL_SSR:    ssr_r  <= mtxu_merge(ssr_r, wdata_r, wstrb_r);
          `MTXU_SEL_SR:     sr_r   <= mtxu_merge(sr_r, wdata_r, wstrb_r);
          `MTXU_SEL_VBR:    vbr_r  <= mtxu_merge(vbr_r, wdata_r, wstrb_r);
          default: begin
          end
        endcase
      end
      if (bvalid_r && I_BREADY) begin
        bvalid_r <= 1'b0;
      end
      if (I_ARVALID && O_ARREADY) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_val;
        rresp_r  <= (rd_sel == `MTXU_SEL_NONE) ?
                    `MTXU_RESP_SLVERR : `MTXU_RESP_OKAY;
      end
      if (rvalid_r && I_RREADY) begin
        rvalid_r <= 1'b0;
      end
      if (I_RTE) begin
        sr_r <= ssr_r;
      end
      // Access answer; a fault never completes
      ack_r   <= I_ACC_REQ;
      ok_r    <= I_ACC_REQ && flt == FLT_NONE && !I_ACC_ADDR_ERR;
      fault_r <= I_ACC_REQ && (flt != FLT_NONE || I_ACC_ADDR_ERR);
      if (I_ACC_REQ) begin
        paddr_r <= (flt == FLT_NONE && !I_ACC_ADDR_ERR) ? pa : 32'h00000000;
      end
      exc_r <= take;
      // Hardware capture overrides a same-cycle software write
      if (take) begin
        page_table_entry_high_r[31:10] <= I_ACC_VADDR[31:10];
        tea_r         <= I_ACC_VADDR;
        exception_event_code_r      <= code;
        spc_r         <= I_ACC_IN_SLOT ? I_ACC_BRANCH_PC : I_ACC_PC;
        ssr_r         <= sr_r;
        sr_r          <= sr_r | (32'h1 << `MTXU_SR_MD) |
                         (32'h1 << `MTXU_SR_BL) |
                         (32'h1 << `MTXU_SR_RB);
        target_r      <= vbr_r + vec;
        if (flt == FLT_MISS) begin
          rc_r <= lk_free ? lk_fway : rc_r + 1'b1;
        end else if (flt != FLT_NONE) begin
          rc_r <= lk_way;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // TLB array: load entry and invalidate-all
  // --------------------------------------------------------------------
  wire [EW-1:0] ld_e = {rc_r, mtxu_index(page_table_entry_high_r[16:12], page_table_entry_high_r[4:0], ix_r)};

  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      tlb_v_r <= {NENT{1'b0}};
    end else begin
      if (I_LOAD_TRANSLATION_ENTRY_INSTRUCTION) begin
        tlb_v_r[ld_e] <= page_table_entry_low_r[`MTXU_PAGE_TABLE_ENTRY_LOW_V];
      end
      if (sw_wr && sw_sel == `MTXU_SEL_TRANSLATION_CONTROL_REG && translation_control_reg_wr[`MTXU_TRANSLATION_CONTROL_REG_TI]) begin
        tlb_v_r <= {NENT{1'b0}};
      end
    end
  end

  always @(posedge I_MCLK) begin
    if (I_LOAD_TRANSLATION_ENTRY_INSTRUCTION) begin
      tlb_vpn_r[ld_e]  <= page_table_entry_high_r[31:10];
      tlb_address_space_id_r[ld_e] <= page_table_entry_high_r[7:0];
      tlb_ppn_r[ld_e]  <= page_table_entry_low_r[28:10];
      tlb_pr_r[ld_e]   <= page_table_entry_low_r[`MTXU_PAGE_TABLE_ENTRY_LOW_PR_HI:`MTXU_PAGE_TABLE_ENTRY_LOW_PR_LO];
      tlb_flg_r[ld_e]  <= page_table_entry_low_r[`MTXU_PAGE_TABLE_ENTRY_LOW_SZ:`MTXU_PAGE_TABLE_ENTRY_LOW_SH];
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign O_ACC_ACK    = ack_r;
  assign O_ACC_OK     = ok_r;
  assign O_ACC_FAULT  = fault_r;
  assign O_ACC_PADDR  = paddr_r;
  assign O_EXC_TAKEN  = exc_r;
  assign O_EXC_TARGET = target_r;
  assign O_SR         = sr_r;

endmodule

`default_nettype wire

// ### tb/mtxu_chk_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Checker
// ----
module mtxu_chk (
  input wire logic        I_MCLK,
  input wire logic        I_RESET,
  input wire logic        I_AWVALID,
  input wire logic        I_WVALID,
  input wire logic        I_RREADY,
  input wire logic        I_ACC_REQ,
  input wire logic        I_ACC_REPEAT,
  input wire logic        I_ACC_ADDR_ERR,
  input wire logic        O_AWREADY,
  input wire logic        O_WREADY,
  input wire logic        O_BVALID,
  input wire logic        O_RVALID,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_ACC_ACK,
  input wire logic        O_ACC_OK,
  input wire logic        O_ACC_FAULT,
  input wire logic [31:0] O_ACC_PADDR,
  input wire logic        O_EXC_TAKEN,
  input wire logic [31:0] O_EXC_TARGET,
  input wire logic [31:0] O_SR
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  AST_ACK: assert property (I_ACC_REQ |=> O_ACC_ACK)
    else $error("access answer late");
  AST_NOACK: assert property (!I_ACC_REQ |=> !O_ACC_ACK)
    else $error("answer without access");
  AST_ONE: assert property (O_ACC_ACK |-> O_ACC_OK != O_ACC_FAULT)
    else $error("access both done and refused");
  AST_FPA: assert property (O_ACC_FAULT |-> O_ACC_PADDR == 32'h0)
    else $error("refused access passed an address");
  AST_SRB: assert property (O_EXC_TAKEN |-> O_SR[30:28] == 3'b111
    && O_ACC_FAULT) else $error("status bits not set on entry");
  AST_BLK: assert property (I_ACC_REQ && O_SR[28] |=> !O_EXC_TAKEN)
    else $error("entry while blocked");
  AST_AE: assert property (I_ACC_REQ && I_ACC_ADDR_ERR &&
    !I_ACC_REPEAT |=> O_ACC_FAULT && !O_EXC_TAKEN)
    else $error("address error mishandled");
  AST_TGT: assert property (!O_EXC_TAKEN |-> $stable(O_EXC_TARGET))
    else $error("target moved without entry");
  AST_B: assert property (I_AWVALID && O_AWREADY && I_WVALID &&
    O_WREADY |-> ##[1:2] O_BVALID) else $error("write answer late");
  AST_R: assert property (O_RVALID && !I_RREADY |=> O_RVALID &&
    $stable(O_RDATA)) else $error("read data dropped");
  cover property (O_EXC_TAKEN);
  cover property (I_ACC_REQ && O_SR[28] ##1 O_ACC_FAULT);
  cover property (O_ACC_OK);
endmodule
bind mtxu_top mtxu_chk u_chk (.*);
`default_nettype wire

// ### tb/mtxu_cpu.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Load/store pipeline model
// ----
module mtxu_cpu (
  input  wire logic        i_clk,
  output logic             o_req,
  output logic             o_wr,
  output logic [31:0]      o_va,
  output logic [31:0]      o_pc,
  output logic             o_slot,
  output logic [31:0]      o_bpc,
  output logic             o_rep,
  output logic             o_ae,
  output logic             o_load_translation_entry_instruction,
  output logic             o_rte
);
  int since_ld = 8;
  initial begin
    {o_req, o_wr, o_slot, o_rep, o_ae, o_load_translation_entry_instruction, o_rte} = 7'h00;
    {o_va, o_pc, o_bpc} = 96'h0;
  end
  always @(posedge i_clk) begin
    since_ld <= o_load_translation_entry_instruction ? 0 : since_ld + 1;
  end
  task acc(input logic w, input logic [31:0] va, pc, bpc,
           input logic s, r, e);
    @(posedge i_clk);
    {o_req, o_wr, o_slot, o_rep, o_ae} <= {1'b1, w, s, r, e};
    {o_va, o_pc, o_bpc} <= {va, pc, bpc};
    @(posedge i_clk);
    o_req <= 1'b0;
    {o_va, o_pc, o_bpc} <= ~{va, pc, bpc};
  endtask
  task ld();
    @(posedge i_clk);
    o_load_translation_entry_instruction <= 1'b1;
    @(posedge i_clk);
    o_load_translation_entry_instruction <= 1'b0;
  endtask
  task ret();
    @(posedge i_clk);
    while (since_ld < 2) @(posedge i_clk);
    o_rte <= 1'b1;
    @(posedge i_clk);
    o_rte <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mtxu_defs.vh"
// ----
// Bench
// ----
module tb;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rv, vector_base_register, va, pva, pc, bpc, sv;
  logic [1:0] rs;
  logic [31:0] pg[4], ptl[4];
  wire awr, wr_r, bv, arr, rvl, ack, ok, flt, exc;
  wire req, w, sl, rp, ae, ldt, return_from_exception;
  wire [1:0] br, rr;
  wire [31:0] rd_d, pa, tgt, sr, cva, cpc, cbpc;
  int err_count = 0, samples_checked = 0, cyc = 0, k, c;
  int cs[11] = '{0, 2, 4, 6, 8, 10, 14, 1, 7, 15, 17};
  integer seed = 32'ha4d0c433;
  always #2.5 clk = ~clk;
  mtxu_cpu cpu (.i_clk(clk), .o_req(req), .o_wr(w), .o_va(cva),
    .o_pc(cpc), .o_slot(sl), .o_bpc(cbpc), .o_rep(rp), .o_ae(ae),
    .o_load_translation_entry_instruction(ldt), .o_rte(return_from_exception));
  mtxu_top dut (.I_MCLK(clk), .I_RESET(rst), .I_AWADDR(awa),
    .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hf),
    .I_WVALID(wv), .O_WREADY(wr_r), .O_BRESP(br), .O_BVALID(bv),
    .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
    .O_RDATA(rd_d), .O_RRESP(rr), .O_RVALID(rvl), .I_RREADY(rry),
    .I_ACC_REQ(req), .I_ACC_WRITE(w), .I_ACC_VADDR(cva), .I_ACC_PC(cpc),
    .I_ACC_IN_SLOT(sl), .I_ACC_BRANCH_PC(cbpc), .I_ACC_REPEAT(rp),
    .I_ACC_ADDR_ERR(ae), .I_LOAD_TRANSLATION_ENTRY_INSTRUCTION(ldt), .I_RTE(return_from_exception), .O_ACC_ACK(ack),
    .O_ACC_OK(ok), .O_ACC_FAULT(flt), .O_ACC_PADDR(pa),
    .O_EXC_TAKEN(exc), .O_EXC_TARGET(tgt), .O_SR(sr));
  task finish_test;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test;
    end
  end
  task chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic at, wt, bt;
    @(posedge clk);
    {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
    bt = 0;
    while (!bt) begin
      #1 {at, wt, bt, rs} = {awv & awr, wv & wr_r, bv, br};
      @(posedge clk);
      if (at) awv <= 1'b0;
      if (wt) wv <= 1'b0;
      if (bt) bry <= 1'b0;
    end
  endtask
  task rd(input logic [7:0] a);
    logic at, rt;
    @(posedge clk);
    {ara, arv, rry} <= {a, 2'b11};
    rt = 0;
    while (!rt) begin
      #1 {at, rt, rv, rs} = {arv & arr, rvl, rd_d, rr};
      @(posedge clk);
      if (at) arv <= 1'b0;
      if (rt) rry <= 1'b0;
    end
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  function logic [31:0] f_code(input int k, input logic w, r);
    if (r) return k == 1 ? `MTXU_CODE_RPT_PROT : `MTXU_CODE_RPT;
    if (k == 1) return w ? `MTXU_CODE_PROT_ST : `MTXU_CODE_PROT_LD;
    if (k == 3) return `MTXU_CODE_INITPW;
    return w ? `MTXU_CODE_MISS_ST : `MTXU_CODE_MISS_LD;
  endfunction
  function logic [31:0] f_off(input int k, input logic r);
    if (k != 0) return `MTXU_VEC_FAULT;
    return r ? `MTXU_VEC_RPT_MISS : `MTXU_VEC_MISS;
  endfunction
  task ld(input int k);
    wr(`MTXU_OFF_PAGE_TABLE_ENTRY_HIGH, pg[k] & 32'hfffffc00);
    wr(`MTXU_OFF_PAGE_TABLE_ENTRY_LOW, ptl[k]);
    wr(`MTXU_OFF_TRANSLATION_CONTROL_REG, 32'h1 | (k << 6));
    cpu.ld();
  endtask
  task hit(input int k, input logic w);
    va = pg[k] | ($random(seed) & 32'h3fc);
    cpu.acc(w, va, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
    #1 chk({flt, ok}, 2'b01);
    chk(pa, {3'b000, ptl[k][28:10], va[9:0]});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(`MTXU_OFF_SR, `MTXU_SR_RST);
    rchk(`MTXU_OFF_EXCEPTION_EVENT_CODE, 32'h0);
    rchk(8'hfc, 32'h0);
    chk(rs, `MTXU_RESP_SLVERR);
    wr(8'hfc, 32'h1);
    chk(rs, `MTXU_RESP_SLVERR);
    vector_base_register = $random(seed) & 32'hfffff000;
    wr(`MTXU_OFF_VBR, vector_base_register);
    chk(rs, `MTXU_RESP_OKAY);
    for (k = 0; k < 4; k++) begin
      pg[k] = ($random(seed) & 32'h7ffe0c00) | ((k + 1) << 12);
      ptl[k] = $random(seed) & 32'h1ffffc00;
    end
    ptl[1] |= 32'h124;
    ptl[2] |= 32'h064;
    ptl[3] |= 32'h160;
    for (k = 1; k < 4; k++) ld(k);
    hit(1, 1'b0);
    hit(3, 1'b0);
    foreach (cs[i]) begin
      c = cs[i];
      k = c / 4;
      sv = (k == 1) ? 32'h0 : 32'h40000000;
      wr(`MTXU_OFF_SR, sv);
      va = pg[k == 4 ? 1 : k] | ($random(seed) & 32'h3fc);
      {pc, bpc} = {$random(seed), $random(seed)};
      cpu.acc(c[1], va, pc, bpc, pc[0], c[0], k == 4);
      #1 chk({flt, exc}, 2'b11);
      chk(tgt, vector_base_register + f_off(k, c[0]));
      rchk(`MTXU_OFF_EXCEPTION_EVENT_CODE, f_code(k, c[1], c[0]));
      rchk(`MTXU_OFF_TEA, va);
      rd(`MTXU_OFF_PAGE_TABLE_ENTRY_HIGH);
      chk(rv[31:10], va[31:10]);
      rchk(`MTXU_OFF_SPC, pc[0] ? bpc : pc);
      rchk(`MTXU_OFF_SSR, sv);
      rchk(`MTXU_OFF_SR, 32'h70000000);
      rd(`MTXU_OFF_TRANSLATION_CONTROL_REG);
      if (k < 4) chk(rv[7:6], k);
      pva = va;
    end
    cpu.acc(1'b0, pg[0], 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
    #1 chk({flt, exc}, 2'b10);
    rchk(`MTXU_OFF_TEA, pva);
    ptl[3] |= 32'h4;
    ld(3);
    cpu.ret();
    rchk(`MTXU_OFF_SR, 32'h40000000);
    hit(3, 1'b1);
    cpu.acc(1'b0, pg[0], 32'h0, 32'h0, 1'b0, 1'b0, 1'b1);
    #1 chk({flt, exc}, 2'b10);
    for (k = 0; k < 4; k++) begin
      wr(`MTXU_OFF_PAGE_TABLE_ENTRY_HIGH, (pg[0] & 32'hfffffc00) ^ ((k + 1) << 20));
      wr(`MTXU_OFF_PAGE_TABLE_ENTRY_LOW, 32'h100);
      wr(`MTXU_OFF_TRANSLATION_CONTROL_REG, 32'h1 | (k << 6));
      cpu.ld();
    end
    wr(`MTXU_OFF_TRANSLATION_CONTROL_REG, 32'h41);
    cpu.acc(1'b0, pg[0], 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
    #1 chk({flt, exc}, 2'b11);
    rd(`MTXU_OFF_TRANSLATION_CONTROL_REG);
    chk(rv[7:6], 2'd2);
    wr(`MTXU_OFF_TRANSLATION_CONTROL_REG, 32'h0);
    cpu.acc(1'b1, pg[0], 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
    #1 chk(ok, 1'b1);
    chk(pa, pg[0]);
    finish_test;
  end
endmodule
`default_nettype wire
